// ==== lcac_cluster.sv ====
// logic cell arithmetic cluster with apb register access
//
// The register offsets and the APB slave port are this design's own decisions.
`include "lcac_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lcac_cluster #(
  parameter int CELLS = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cluster results
  output logic [CELLS-1:0] regOut,
  output logic clusterCarryOut
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CELLS < 2 || CELLS > 16) begin : g_bad_cells
    $error("lcac_cluster: CELLS must lie between 2 and 16");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  lcac_pkg::lcac_apb_req_s req;
  lcac_pkg::lcac_ctrl_s ctrl;
  logic [CELLS-1:0] mode;
  logic [CELLS-1:0] operandA;
  logic [CELLS-1:0] operandB;
  logic [CELLS-1:0] dataC;
  logic [CELLS-1:0] dataD;
  logic [CELLS-1:0] loadData;
  logic [`LCAC_LUT_W-1:0] lutMask;
  logic [CELLS-1:0] cellReg;
  logic [CELLS-1:0] combOut;
  logic [CELLS-1:0] next_cellReg;
  logic [CELLS:0] carryPathZero;
  logic [CELLS:0] carryPathOne;
  logic [CELLS:0] lutChain;
  logic subtract;
  logic clusterCarryIn;
  logic next_clusterCarryOut;
  logic setupPhase;
  logic writeAccess;
  logic [7:0] regAddr;
  logic addrMapped;
  logic [31:0] next_prdata;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setupPhase = req.psel & ~req.penable;
  assign writeAccess = req.psel & req.penable & pready & req.pwrite & ~pslverr;
  assign regAddr = req.paddr[7:0];

  always_comb begin
    addrMapped = (req.paddr[31:8] == 24'h000000) && (regAddr[1:0] == 2'h0) &&
                 (regAddr <= `LCAC_OFS_COMB);
    next_prdata = 32'h00000000;
    unique case (regAddr)
      `LCAC_OFS_CTRL: next_prdata = 32'(ctrl);
      `LCAC_OFS_MODE: next_prdata = 32'(mode);
      `LCAC_OFS_OPA: next_prdata = 32'(operandA);
      `LCAC_OFS_OPB: next_prdata = 32'(operandB);
      `LCAC_OFS_DATC: next_prdata = 32'(dataC);
      `LCAC_OFS_DATD: next_prdata = 32'(dataD);
      `LCAC_OFS_LOAD: next_prdata = 32'(loadData);
      `LCAC_OFS_LUT: next_prdata = 32'(lutMask);
      `LCAC_OFS_REGOUT: next_prdata = 32'(cellReg);
      `LCAC_OFS_COMB: begin
        next_prdata = 32'(combOut);
        next_prdata[`LCAC_COMB_CO0_BIT] = carryPathZero[CELLS];
        next_prdata[`LCAC_COMB_CO1_BIT] = carryPathOne[CELLS];
        next_prdata[`LCAC_COMB_CSEL_BIT] = clusterCarryIn;
      end
      default: next_prdata = 32'h00000000;
    endcase
  end

  // one wait-free access cycle: answer prepared in the setup cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  // unmapped or misaligned addresses are refused, the write is dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupPhase & ~addrMapped;
    end
  end

  // read data stands from the access cycle until the next setup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setupPhase && !req.pwrite && addrMapped) begin
      prdata <= next_prdata;
    end else if (setupPhase) begin
      prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= lcac_pkg::lcac_ctrl_s'(`LCAC_CTRL_RST);
    end else if (writeAccess && regAddr == `LCAC_OFS_CTRL) begin
      ctrl <= lcac_pkg::lcac_ctrl_s'(req.pwdata[`LCAC_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= '0;
    end else if (writeAccess && regAddr == `LCAC_OFS_MODE) begin
      mode <= req.pwdata[CELLS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      operandA <= '0;
    end else if (writeAccess && regAddr == `LCAC_OFS_OPA) begin
      operandA <= req.pwdata[CELLS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      operandB <= '0;
    end else if (writeAccess && regAddr == `LCAC_OFS_OPB) begin
      operandB <= req.pwdata[CELLS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataC <= '0;
    end else if (writeAccess && regAddr == `LCAC_OFS_DATC) begin
      dataC <= req.pwdata[CELLS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dataD <= '0;
    end else if (writeAccess && regAddr == `LCAC_OFS_DATD) begin
      dataD <= req.pwdata[CELLS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loadData <= '0;
    end else if (writeAccess && regAddr == `LCAC_OFS_LOAD) begin
      loadData <= req.pwdata[CELLS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lutMask <= `LCAC_LUT_RST;
    end else if (writeAccess && regAddr == `LCAC_OFS_LUT) begin
      lutMask <= req.pwdata[`LCAC_LUT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // cluster-wide carry control
  // ----------------------------------------------------------------
  assign subtract = ~ctrl.addNotSub;

  // first cell holds the lsb; subtract or up-count forces its carry to one
  always_comb begin
    if (lcac_pkg::lcac_mode_e'(mode[0]) == lcac_pkg::LCAC_ARITH && dataC[0]) begin
      clusterCarryIn = dataD[0];
    end else begin
      clusterCarryIn = subtract | ctrl.carryIn;
    end
  end

  // the zero chain assumes carry 0 into the first cell, the one chain carry 1
  assign carryPathZero[0] = 1'b0;
  assign carryPathOne[0] = 1'b1;
  assign lutChain[0] = 1'b0;

  // ----------------------------------------------------------------
  // logic cells
  // ----------------------------------------------------------------
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic arith;
    logic counting;
    logic opA;
    logic opB;
    logic sumZero;
    logic sumOne;
    logic carryZero;
    logic carryOne;
    logic selectedCarry;
    logic arithOut;
    logic inC;
    logic inD;
    logic lutOut;
    logic regChainIn;
    logic [3:0] lutIndex;

    assign arith = lcac_pkg::lcac_mode_e'(mode[i]) == lcac_pkg::LCAC_ARITH;
    // per-cell count enable and direction ride on data inputs c and d
    assign counting = arith & dataC[i];
    assign opA = counting ? cellReg[i] : operandA[i];
    // up adds 0 with carry 1, down adds all ones; else B inverted on subtract
    assign opB = counting ? ~dataD[i] : (operandB[i] ^ subtract);

    // four two-input tables: two sums, two carry-outs
    assign sumZero = opA ^ opB;
    assign sumOne = ~(opA ^ opB);
    assign carryZero = opA & opB;
    assign carryOne = opA | opB;

    // each chain selects its own carry-out
    assign carryPathZero[i+1] = carryPathZero[i] ? carryOne : carryZero;
    assign carryPathOne[i+1] = carryPathOne[i] ? carryOne : carryZero;

    // cluster carry picks a chain, that chain's level picks the sum
    assign selectedCarry = clusterCarryIn ? carryPathOne[i] : carryPathZero[i];
    assign arithOut = selectedCarry ? sumOne : sumZero;

    // normal mode four-input table, inputs a, b, c, d
    assign inC = ctrl.packEn ? cellReg[i] : dataC[i];
    assign inD = ctrl.lutChainEn ? lutChain[i] : dataD[i];
    assign lutIndex = {inD, inC, operandB[i], operandA[i]};
    assign lutOut = lutMask[lutIndex];
    assign lutChain[i+1] = lutOut;

    // unregistered result, registered copy is cellReg
    assign combOut[i] = arith ? arithOut : lutOut;

    if (i == 0) begin : g_head
      assign regChainIn = ctrl.shiftIn;
    end else begin : g_tail
      assign regChainIn = cellReg[i-1];
    end

    always_comb begin
      if (!arith && ctrl.regChainEn) begin
        next_cellReg[i] = regChainIn;
      end else begin
        next_cellReg[i] = combOut[i];
      end
    end
  end

  assign next_clusterCarryOut = clusterCarryIn ? carryPathOne[CELLS] : carryPathZero[CELLS];

  // ----------------------------------------------------------------
  // cell registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cellReg <= '0;
    end else if (ctrl.clkEn) begin
      if (ctrl.syncClear) begin
        cellReg <= '0;
      end else if (ctrl.syncLoad) begin
        cellReg <= loadData;
      end else begin
        cellReg <= next_cellReg;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clusterCarryOut <= 1'b0;
    end else begin
      clusterCarryOut <= next_clusterCarryOut;
    end
  end

  assign regOut = cellReg;

endmodule // lcac_cluster
`default_nettype wire

// ==== lcac_cluster_asserts.sv ====
// port checker of the logic cell arithmetic cluster
`timescale 1ns/1ps
`default_nettype none
module lcac_cluster_asserts #(
  parameter int CELLS = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // results
  input wire logic [CELLS-1:0] regOut,
  input wire logic clusterCarryOut
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic ctrlWr;
  assign ctrlWr = pready && pwrite && paddr == 32'h00000000;
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  chk_idle_quiet: assert property (!psel |-> !pready)
    else $error("answer without select");
  chk_err_unmapped: assert property (pready && paddr[31:8] != 24'h000000 |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && paddr <= 32'h24 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_data_zero: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h00000000)
    else $error("read data not zero");
  chk_clear_all: assert property (ctrlWr && pwdata[2:1] == 2'h3 |-> ##2 regOut == '0)
    else $error("clear missed a register");
  chk_hold_off: assert property (ctrlWr && !pwdata[1] |=> ##1 $stable(regOut) [*2])
    else $error("registers moved while disabled");
endmodule // lcac_cluster_asserts
bind lcac_cluster lcac_cluster_asserts #(.CELLS(CELLS)) u_chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .regOut(regOut), .clusterCarryOut(clusterCarryOut));
`default_nettype wire

// ==== lcac_consts.svh ====
// constants of the logic cell arithmetic cluster: offsets, fields, reset values
//
// Functional notes
// - ten cells share one set of cluster controls
// - table output cascades into next cell's table
// - register output cascades into next cell's register
// - packing feeds cell register back into table
// - each cell is normal or dynamic arithmetic
// - cell has eight inputs incl. carries, cascade
// - arithmetic uses four two-input tables per cell
// - cluster carry picks chain; chain picks sum
// - each carry chain selects its own carry-out
// - registered and unregistered results both available
// - add/subtract select chooses A+B or A-B
// - subtract inverts B and forces carry one
// - arithmetic offers enable, count, clear, load options
// - count enable, direction come from data inputs
// - clear and load act on every cell register
`ifndef LCAC_CONSTS_SVH
`define LCAC_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LCAC_OFS_CTRL 8'h00
`define LCAC_OFS_MODE 8'h04
`define LCAC_OFS_OPA 8'h08
`define LCAC_OFS_OPB 8'h0C
`define LCAC_OFS_DATC 8'h10
`define LCAC_OFS_DATD 8'h14
`define LCAC_OFS_LOAD 8'h18
`define LCAC_OFS_LUT 8'h1C
`define LCAC_OFS_REGOUT 8'h20
`define LCAC_OFS_COMB 8'h24

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define LCAC_CTRL_W 9
`define LCAC_CTRL_RST 9'h003
`define LCAC_COMB_CO0_BIT 16
`define LCAC_COMB_CO1_BIT 17
`define LCAC_COMB_CSEL_BIT 18
`define LCAC_LUT_W 16
`define LCAC_LUT_RST 16'h0000

`endif

// ==== lcac_next_cluster.sv ====
// model of the next chained cluster, capturing the cluster carry
`timescale 1ns/1ps
`default_nettype none
module lcac_next_cluster (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // from the cluster below
  input wire logic carryIn,
  // captured value
  output logic carryCaught
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      carryCaught <= 1'b0;
    end else begin
      carryCaught <= carryIn;
    end
  end
endmodule // lcac_next_cluster
`default_nettype wire

// ==== lcac_pkg.sv ====
// types of the logic cell arithmetic cluster
`default_nettype none
package lcac_pkg;

  // cell operating mode, one bit per cell in the mode register
  typedef enum logic {
    LCAC_NORMAL,
    LCAC_ARITH
  } lcac_mode_e;

  // cluster-wide control word, bit 0 is addNotSub
  typedef struct packed {
    logic shiftIn;
    logic regChainEn;
    logic packEn;
    logic lutChainEn;
    logic carryIn;
    logic syncLoad;
    logic syncClear;
    logic clkEn;
    logic addNotSub;
  } lcac_ctrl_s;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } lcac_apb_req_s;

endpackage
`default_nettype wire

// ==== tb_top.sv ====
// self-checking testbench of the logic cell arithmetic cluster
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  lcac_pkg::lcac_apb_req_s req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] regOut;
  logic carryOut;
  logic carryCaught;
  logic [31:0] rdData;
  logic rdErr;
  int errCount = 0;
  int totalChecks = 0;
  lcac_cluster #(.CELLS(10)) u_dut (.clock(clock), .rst_n(rst_n), .psel(req.psel),
    .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .regOut(regOut),
    .clusterCarryOut(carryOut));
  lcac_next_cluster u_next (.clock(clock), .rst_n(rst_n), .carryIn(carryOut),
    .carryCaught(carryCaught));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready === 1'b1) begin
      rdData = prdata;
      rdErr = pslverr;
      req <= '{1'b0, 1'b0, wr, a, d};
    end else begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
      finish_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic comb(input logic [31:0] exp);
    apb(1'b0, 32'h24, 32'h0);
    cmp(rdData & 32'h3FF, exp);
  endtask
  task automatic reg_is(input logic [31:0] exp);
    repeat (2) @(posedge clock);
    cmp({22'h0, regOut}, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    cmp({22'h0, regOut}, 32'h0);
    apb(1'b1, 32'h100, 32'h0);
    cmp({31'h0, rdErr}, 32'h1);
    apb(1'b0, 32'h00, 32'h0);
    cmp(rdData, 32'h003);
    apb(1'b0, 32'h100, 32'h0);
    cmp({31'h0, rdErr}, 32'h1);
  endtask
  task automatic s_arith;
    wr(32'h08, 32'h3);
    wr(32'h0C, 32'h5);
    wr(32'h04, 32'h3FF);
    apb(1'b0, 32'h04, 32'h0);
    cmp(rdData, 32'h3FF);
    reg_is(32'h008);
    wr(32'h00, 32'h002);
    reg_is(32'h3FE);
    comb(32'h3FE);
    wr(32'h08, 32'h3FF);
    wr(32'h0C, 32'h1);
    wr(32'h00, 32'h003);
    repeat (4) @(posedge clock);
    cmp({21'h0, carryCaught, regOut}, 32'h400);
    wr(32'h0C, 32'h0);
    wr(32'h00, 32'h013);
    reg_is(32'h000);
    apb(1'b0, 32'h24, 32'h0);
    cmp(rdData, 32'h60000);
  endtask
  task automatic s_clear_load;
    wr(32'h18, 32'h155);
    wr(32'h00, 32'h00B);
    reg_is(32'h155);
    wr(32'h00, 32'h00F);
    reg_is(32'h000);
    wr(32'h00, 32'h009);
    reg_is(32'h000);
  endtask
  task automatic s_count;
    wr(32'h18, 32'h3FE);
    wr(32'h10, 32'h3FF);
    wr(32'h14, 32'h3FF);
    wr(32'h00, 32'h00B);
    wr(32'h00, 32'h003);
    wr(32'h00, 32'h001);
    reg_is(32'h001);
    wr(32'h14, 32'h0);
    wr(32'h00, 32'h003);
    wr(32'h00, 32'h001);
    reg_is(32'h3FE);
  endtask
  task automatic s_normal;
    wr(32'h04, 32'h0);
    wr(32'h00, 32'h007);
    wr(32'h00, 32'h183);
    wr(32'h00, 32'h081);
    reg_is(32'h007);
    wr(32'h1C, 32'h8000);
    wr(32'h0C, 32'h3FF);
    wr(32'h10, 32'h3FF);
    wr(32'h14, 32'h3FF);
    wr(32'h00, 32'h041);
    comb(32'h007);
    wr(32'h00, 32'h021);
    comb(32'h000);
    wr(32'h00, 32'h001);
    comb(32'h3FF);
    wr(32'h00, 32'h003);
    reg_is(32'h3FF);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    s_reset();
    s_arith();
    s_clear_load();
    s_count();
    s_normal();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
